// File: vims_defs.vh
// shared constants for the video input mode select block
`ifndef VIMS_DEFS_VH
`define VIMS_DEFS_VH
`define VIMS_MODE_LINK 2'h0
`define VIMS_MODE_TV 2'h1
`define VIMS_MODE_DAC 2'h2
`define VIMS_IDF_RGB_MAX 3'h3
`define VIMS_IDF_YC 3'h4
`define VIMS_DVD_NONE 2'h0
`define VIMS_DVD_INTERLACED 2'h1
`define VIMS_DVD_PROGRESSIVE 2'h2
`define VIMS_DW 12
`define VIMS_PW 24
`define VIMS_SYNC_DIV 4
`endif

// File: vims_sync3.v
// three-stage synchroniser with agreement filter for a W-bit group of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module vims_sync3 #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire clk,
    input wire rst_b,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer i;
    always @(posedge clk) begin
        if (!rst_b) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            sync_out <= INIT;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // a bit changes only once stages two and three agree
            for (i = 0; i < W; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    sync_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: vims_top.v
// video input capture, pixel pairing and output path selection
//
// Overview of operation
// [RULE_01] only one output path, link or tv, runs at any time
// [RULE_02] link mode takes two-word data with clock at one or two times pixel rate
// [RULE_03] controller keeps link pixel rate below its limit
// [RULE_04] link output needs an rgb input format, never luminance/chroma
// [RULE_05] a dac bypass path sends captured pixels straight to the dacs
// [RULE_06] tv syncs come from controller or, optionally, from this device
// [RULE_07] device-driven sync is not used above its pixel frequency limit
// [RULE_08] tv mode may drive a pixel reference clock to the controller
// [RULE_09] tv mode hands pixels to the encoder for ntsc or pal
// [RULE_10] clock at pixel rate captures a word on both edges
// [RULE_11] clock at twice pixel rate captures on one chosen edge
// [RULE_12] a configuration setting inverts the captured pixel clock polarity
// [RULE_13] interlaced dvd tv modes bypass scan conversion and flicker filter
// [RULE_14] progressive dvd tv modes keep scan conversion active
// [RULE_15] controller sends dvd link resolutions as progressive rgb
// [RULE_16] widest 16:9 link mode refresh is limited by scan type
// [RULE_17] a dedicated bit selects which clock edge counts as rising
// [RULE_18] a three-bit field selects four rgb formats or luminance/chroma
// [RULE_19] first word after hsync leading edge is first word of a pair
// [RULE_20] mode, ratio, sync direction, reference enable held as static config
`timescale 1ns/10ps
`default_nettype none
`include "vims_defs.vh"
module vims_top #(
    parameter DW = `VIMS_DW,
    parameter PW = `VIMS_PW,
    parameter SYNC_DIV = `VIMS_SYNC_DIV
) (
    input wire clk,
    input wire rst_b,
    input wire input_pixel_clock_pos,
    input wire input_pixel_clock_neg,
    input wire [DW-1:0] pix_bus_in,
    input wire hsync_in,
    input wire vsync_in,
    input wire pixel_data_enable,
    input wire [1:0] out_mode,
    input wire clock_ratio_2x,
    input wire capture_clock_polarity,
    input wire [2:0] input_format_select,
    input wire sync_out_en,
    input wire ref_clk_en,
    input wire tv_std_pal,
    input wire [1:0] dvd_mode,
    output reg [DW-1:0] pix_bus_out,
    output reg pix_bus_oe_b,
    output reg hsync_out,
    output reg vsync_out,
    output reg sync_oe_b,
    output reg ref_clk_out,
    output reg [PW-1:0] link_pixel,
    output reg link_valid,
    output reg [PW-1:0] tv_pixel,
    output reg tv_valid,
    output reg tv_pal,
    output reg scan_conv_bypass,
    output reg flicker_bypass,
    output reg [PW-1:0] dac_pixel,
    output reg dac_valid,
    output reg pair_first,
    output reg format_error
);
    // input pins pass the three-stage filter; clock pins in one vector keep them aligned
    wire [1:0] clk_pins_s;
    wire [DW+2:0] dat_s;
    // with the polarity bit clear the reset level matches an idle pin pair, so no false capture edge follows reset
    vims_sync3 #(.W(2), .INIT(2'h1)) u_sync_clk (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({input_pixel_clock_pos, input_pixel_clock_neg}),
        .sync_out(clk_pins_s)
    );
    vims_sync3 #(.W(DW+3), .INIT({(DW+3){1'b0}})) u_sync_dat (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({hsync_in, vsync_in, pixel_data_enable, pix_bus_in}),
        .sync_out(dat_s)
    );
    // static configuration registers
    reg [1:0] mode_r;
    reg ratio2x_r;
    reg pol_r;
    reg [2:0] idf_r;
    reg syncdrv_r;
    reg refen_r;
    always @(posedge clk) begin
        if (!rst_b) begin
            mode_r <= `VIMS_MODE_LINK;
            ratio2x_r <= 1'b0;
            pol_r <= 1'b0;
            idf_r <= 3'h0;
            syncdrv_r <= 1'b0;
            refen_r <= 1'b0;
        end else begin
            mode_r <= out_mode; // [RULE_20]
            ratio2x_r <= clock_ratio_2x; // [RULE_20]
            pol_r <= capture_clock_polarity; // [RULE_12]
            idf_r <= input_format_select; // [RULE_18]
            syncdrv_r <= sync_out_en; // [RULE_20]
            refen_r <= ref_clk_en; // [RULE_20]
        end
    end
    // differential clock; if the neg pin is tied to vref it reads as a steady level
    wire diff_clk = clk_pins_s[1] & ~clk_pins_s[0];
    // polarity bit selects which transition of the pair counts as rising
    wire eff_clk = diff_clk ^ pol_r; // [RULE_12] [RULE_17]
    reg eff_clk_r;
    always @(posedge clk) begin
        if (!rst_b) begin
            eff_clk_r <= 1'b0;
        end else begin
            eff_clk_r <= eff_clk;
        end
    end
    wire rise = eff_clk & ~eff_clk_r;
    wire fall = ~eff_clk & eff_clk_r;
    // 2x clock latches on the chosen rising edge only, 1x clock on both
    wire cap = ratio2x_r ? rise : (rise | fall); // [RULE_10] [RULE_11]
    wire [DW-1:0] d_s = dat_s[DW-1:0];
    wire h_s = dat_s[DW+2];
    wire v_s = dat_s[DW+1];
    wire de_s = dat_s[DW];
    reg h_prev_r;
    reg hs_armed_r;
    reg phase_r;
    reg [DW-1:0] first_r;
    reg [PW-1:0] pix_r;
    reg pix_v_r;
    reg [PW-1:0] pix_nxt;
    wire [DW-1:0] w0 = first_r;
    wire [DW-1:0] w1 = d_s;
    // reassemble one pixel from its two words per input format
    always @* begin
        pix_nxt = {PW{1'b0}};
        case (idf_r)
            3'h0: begin
                pix_nxt = {w1[11:4], w1[3:0], w0[11:8], w0[7:0]};
            end
            3'h1: begin
                pix_nxt = {w1[11:7], w0[3], w0[7:6],
                    w1[6:4], w0[11:9], w0[0], w1[0],
                    w0[8:4], w0[2:1], 1'b0};
            end
            3'h2: begin
                pix_nxt = {w1[11:7], 3'h0, w1[6:4], w0[11:9], 2'h0,
                    w0[8:4], 3'h0};
            end
            3'h3: begin
                pix_nxt = {w1[10:6], 3'h0, w1[5:4], w0[11:9], 3'h0,
                    w0[8:4], 3'h0};
            end
            `VIMS_IDF_YC: begin
                pix_nxt = {8'h00, w0[7:0], w1[7:0]};
            end
            default: begin
                pix_nxt = {PW{1'b0}};
            end
        endcase
    end
    always @(posedge clk) begin
        if (!rst_b) begin
            h_prev_r <= 1'b0;
            hs_armed_r <= 1'b0;
            phase_r <= 1'b0;
            first_r <= {DW{1'b0}};
            pix_r <= {PW{1'b0}};
            pix_v_r <= 1'b0;
        end else begin
            pix_v_r <= 1'b0;
            h_prev_r <= h_s;
            if (h_s & ~h_prev_r) begin
                hs_armed_r <= 1'b1;
            end
            if (cap) begin
                if (hs_armed_r | (h_s & ~h_prev_r)) begin
                    // word after hsync leading edge opens a pair
                    hs_armed_r <= 1'b0;
                    first_r <= d_s; // [RULE_19]
                    phase_r <= de_s;
                end else if (!de_s) begin
                    phase_r <= 1'b0;
                end else if (!phase_r) begin
                    first_r <= d_s; // [RULE_02]
                    phase_r <= 1'b1;
                end else begin
                    pix_r <= pix_nxt; // [RULE_02]
                    pix_v_r <= 1'b1;
                    phase_r <= 1'b0;
                end
            end
        end
    end
    // rgb formats only on the link; a luminance/chroma selection blocks it
    wire link_fmt_ok = (idf_r <= `VIMS_IDF_RGB_MAX); // [RULE_04]
    wire is_link = (mode_r == `VIMS_MODE_LINK);
    wire is_tv = (mode_r == `VIMS_MODE_TV);
    wire is_dac = (mode_r == `VIMS_MODE_DAC);
    always @(posedge clk) begin
        if (!rst_b) begin
            link_pixel <= {PW{1'b0}};
            link_valid <= 1'b0;
            tv_pixel <= {PW{1'b0}};
            tv_valid <= 1'b0;
            tv_pal <= 1'b0;
            dac_pixel <= {PW{1'b0}};
            dac_valid <= 1'b0;
            scan_conv_bypass <= 1'b0;
            flicker_bypass <= 1'b0;
            pair_first <= 1'b0;
            format_error <= 1'b0;
        end else begin
            // mode is one-hot decoded, so the three valid outputs never run together
            link_valid <= pix_v_r & is_link & link_fmt_ok; // [RULE_01] [RULE_04]
            link_pixel <= is_link ? pix_r : {PW{1'b0}};
            tv_valid <= pix_v_r & is_tv; // [RULE_09] [RULE_01]
            tv_pixel <= is_tv ? pix_r : {PW{1'b0}};
            tv_pal <= tv_std_pal; // [RULE_09]
            dac_valid <= pix_v_r & is_dac; // [RULE_05]
            dac_pixel <= is_dac ? pix_r : {PW{1'b0}};
            scan_conv_bypass <= is_tv & (dvd_mode == `VIMS_DVD_INTERLACED); // [RULE_13] [RULE_14]
            flicker_bypass <= is_tv & (dvd_mode == `VIMS_DVD_INTERLACED); // [RULE_13]
            pair_first <= cap & ~phase_r & de_s;
            format_error <= is_link & ~link_fmt_ok; // [RULE_04]
        end
    end
    // device-generated sync and reference clock, from a divider enable
    reg [7:0] div_r;
    reg [9:0] hcnt_r;
    reg [9:0] vcnt_r;
    wire tick = (div_r == SYNC_DIV - 1);
    always @(posedge clk) begin
        if (!rst_b) begin
            div_r <= 8'h00;
            hcnt_r <= 10'h000;
            vcnt_r <= 10'h000;
            ref_clk_out <= 1'b0;
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
            sync_oe_b <= 1'b1;
            pix_bus_out <= {DW{1'b0}};
            pix_bus_oe_b <= 1'b1;
        end else begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            if (tick) begin
                ref_clk_out <= is_tv & refen_r & ~ref_clk_out; // [RULE_08]
                hcnt_r <= hcnt_r + 10'h001;
                if (hcnt_r == 10'h3ff) begin
                    vcnt_r <= vcnt_r + 10'h001;
                end
            end
            // drive syncs only in tv mode with the option set; low speed use only
            sync_oe_b <= ~(is_tv & syncdrv_r); // [RULE_06] [RULE_07]
            hsync_out <= is_tv & syncdrv_r & (hcnt_r[9:6] == 4'h0); // [RULE_06]
            vsync_out <= is_tv & syncdrv_r & (vcnt_r[9:2] == 8'h00); // [RULE_06]
            pix_bus_out <= {DW{1'b0}};
            pix_bus_oe_b <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: vims_checker.sv
// concurrent checks on the mode select block's ports
`timescale 1ns/10ps
`default_nettype none
`include "vims_defs.vh"
module vims_checker #(
    parameter SYNC_DIV = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] out_mode,
    input wire logic [2:0] input_format_select,
    input wire logic sync_out_en,
    input wire logic ref_clk_en,
    input wire logic [1:0] dvd_mode,
    input wire logic link_valid,
    input wire logic tv_valid,
    input wire logic dac_valid,
    input wire logic format_error,
    input wire logic scan_conv_bypass,
    input wire logic flicker_bypass,
    input wire logic sync_oe_b,
    input wire logic ref_clk_out
);
    localparam int RB = SYNC_DIV;
    wire logic tv = out_mode == `VIMS_MODE_TV;
    wire logic yc = out_mode == `VIMS_MODE_LINK && input_format_select == `VIMS_IDF_YC;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    one_path_a: assert property ($onehot0({link_valid, tv_valid, dac_valid}))
        else $error("paths overlap");
    link_route_a: assert property (link_valid |-> out_mode == 2'h0 && !yc)
        else $error("bad link pixel");
    dac_route_a: assert property (dac_valid |-> out_mode == `VIMS_MODE_DAC)
        else $error("bad dac pixel");
    fmt_flag_a: assert property (yc [*3] |-> format_error)
        else $error("no format error");
    dvd_bypass_a: assert property (
        (tv && dvd_mode == `VIMS_DVD_INTERLACED) [*3] |-> scan_conv_bypass && flicker_bypass)
        else $error("no dvd bypass");
    scan_keep_a: assert property (
        (tv && dvd_mode == `VIMS_DVD_PROGRESSIVE) [*3] |-> !scan_conv_bypass)
        else $error("scan bypassed");
    sync_drive_a: assert property ((tv && sync_out_en) [*3] |-> !sync_oe_b)
        else $error("sync not driven");
    sync_idle_a: assert property (!(tv && sync_out_en) [*3] |-> sync_oe_b)
        else $error("sync driven");
    ref_run_a: assert property ((tv && ref_clk_en) [*8] |-> ##[0:RB] $changed(ref_clk_out))
        else $error("ref clock stuck");
    link_gap_a: assert property (link_valid |=> !link_valid [*4])
        else $error("link pulses too close");
    cover property (link_valid);
    cover property (tv_valid);
    cover property (dac_valid);
endmodule
bind vims_top vims_checker #(.SYNC_DIV(SYNC_DIV)) i_vims_checker (.clk(clk), .rst_b(rst_b),
    .out_mode(out_mode), .input_format_select(input_format_select), .sync_out_en(sync_out_en),
    .ref_clk_en(ref_clk_en), .dvd_mode(dvd_mode), .link_valid(link_valid), .tv_valid(tv_valid),
    .dac_valid(dac_valid), .format_error(format_error), .scan_conv_bypass(scan_conv_bypass),
    .flicker_bypass(flicker_bypass), .sync_oe_b(sync_oe_b), .ref_clk_out(ref_clk_out));
`default_nettype wire

// File: vims_gfx_ctrl.sv
// behavioural graphics controller driving the pixel port
`timescale 1ns/10ps
`default_nettype none
module vims_gfx_ctrl (
    input wire logic pol,
    output wire logic clk_p,
    output wire logic clk_n,
    output var logic [11:0] d,
    output var logic hs,
    output var logic vs,
    output var logic de
);
    logic e = 1'b0;
    // pol swaps the pin pair so the capture edge keeps its place
    assign clk_p = e ^ pol;
    assign clk_n = ~clk_p;
    initial begin
        d = 12'h000;
        hs = 1'b0;
        vs = 1'b0;
        de = 1'b0;
    end
    // 80 ns period keeps the pixel rate far under both limits
    task automatic word(input logic [11:0] w, input logic x2);
        d = w;
        de = 1'b1;
        #20 e = x2 | ~e;
        #20;
        if (x2) begin
            e = 1'b0;
            #40;
        end
    endtask
    // frames sent are progressive rgb or luminance/chroma, refresh far under any limit
    // two words per pixel; clock stands still between pixels
    task automatic pix(input logic [11:0] a, input logic [11:0] b, input logic x2);
        word(a, x2);
        word(b, x2);
        de = 1'b0;
        d = ~d;
        #40;
    endtask
    task automatic hpulse;
        hs = 1'b1;
        #100 hs = 1'b0;
        #100;
    endtask
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the video input mode select block
`timescale 1ns/10ps
`default_nettype none
`include "vims_defs.vh"
module tb;
    typedef struct {logic [1:0] m; logic x2, pol; logic [2:0] f; logic [11:0] a, b;} vims_row_t;
    vims_row_t rows[8] = '{'{2'h0, 1'b0, 1'b0, 3'h0, 12'ha5c, 12'h3e1},
        '{2'h0, 1'b1, 1'b0, 3'h0, 12'h123, 12'h456}, '{2'h0, 1'b1, 1'b1, 3'h1, 12'h789, 12'habc},
        '{2'h0, 1'b0, 1'b1, 3'h0, 12'hf0f, 12'h0f0}, '{2'h1, 1'b0, 1'b0, 3'h2, 12'h321, 12'h654},
        '{2'h1, 1'b1, 1'b0, 3'h4, 12'h080, 12'h0eb}, '{2'h2, 1'b0, 1'b0, 3'h0, 12'h5a5, 12'ha5a},
        '{2'h2, 1'b1, 1'b1, 3'h3, 12'h3c3, 12'hc3c}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] mode = 2'h3;
    logic x2 = 1'b0;
    logic pol = 1'b0;
    logic [2:0] fmt = 3'h0;
    logic sync_en = 1'b0;
    logic ref_en = 1'b0;
    logic pal = 1'b0;
    logic [1:0] dvd = 2'h0;
    logic r0;
    wire clk_p, clk_n, hs, vs, de, fmt_err, scb, ffb, soe_b, ref_clk, pal_o, poe_b;
    wire hs_o, vs_o;
    wire [11:0] d;
    wire [23:0] px[3];
    wire [2:0] vld;
    int miscompares = 0;
    int num_checks = 0;
    int cnt[3] = '{0, 0, 0};
    int b[3];
    vims_gfx_ctrl i_vims_gfx_ctrl (.pol(pol), .clk_p(clk_p), .clk_n(clk_n), .d(d), .hs(hs),
        .vs(vs), .de(de));
    vims_top i_vims_top (.clk(clk), .rst_b(rst_b), .input_pixel_clock_pos(clk_p),
        .input_pixel_clock_neg(clk_n), .pix_bus_in(d), .hsync_in(hs), .vsync_in(vs),
        .pixel_data_enable(de), .out_mode(mode), .clock_ratio_2x(x2), .capture_clock_polarity(pol),
        .input_format_select(fmt), .sync_out_en(sync_en), .ref_clk_en(ref_en), .tv_std_pal(pal),
        .dvd_mode(dvd), .pix_bus_out(), .pix_bus_oe_b(poe_b), .hsync_out(hs_o), .vsync_out(vs_o),
        .sync_oe_b(soe_b), .ref_clk_out(ref_clk), .link_pixel(px[0]), .link_valid(vld[0]),
        .tv_pixel(px[1]), .tv_valid(vld[1]), .tv_pal(pal_o), .scan_conv_bypass(scb),
        .flicker_bypass(ffb), .dac_pixel(px[2]), .dac_valid(vld[2]), .pair_first(),
        .format_error(fmt_err));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        for (int k = 0; k < 3; k++) if (vld[k] === 1'b1) cnt[k]++;
    end
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic run(input vims_row_t r, input logic stray);
        mode = r.m;
        x2 = r.x2;
        pol = r.pol;
        fmt = r.f;
        repeat (8) @(negedge clk);
        b = cnt;
        if (stray) begin
            i_vims_gfx_ctrl.word(12'hfff, r.x2);
            i_vims_gfx_ctrl.hpulse();
        end
        i_vims_gfx_ctrl.pix(r.a, r.b, r.x2);
        for (int k = 0; k < 40 && cnt[r.m] == b[r.m]; k++) @(negedge clk);
        chk("paths", 24'h1 << (8 * r.m), {8'(cnt[2] - b[2]), 8'(cnt[1] - b[1]), 8'(cnt[0] - b[0])});
        if (r.f == 3'h0 || r.f == 3'h4) chk("pixel", r.f[2] ? {8'h00, r.a[7:0], r.b[7:0]} : {r.b, r.a}, px[r.m]);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        chk("oe reset", 24'h3, {22'h0, soe_b, poe_b});
        rst_b = 1'b1;
        foreach (rows[k]) run(rows[k], 1'b0);
        run('{2'h0, 1'b1, 1'b0, 3'h0, 12'h0f0, 12'h5aa}, 1'b1);
        fmt = `VIMS_IDF_YC;
        x2 = 1'b0;
        b = cnt;
        i_vims_gfx_ctrl.pix(12'h010, 12'h080, 1'b0);
        repeat (40) @(negedge clk);
        chk("yc link", {8'(cnt[0] - b[0]), 16'h1}, {8'h0, 15'h0, fmt_err});
        mode = `VIMS_MODE_TV;
        sync_en = 1'b1;
        ref_en = 1'b1;
        pal = 1'b1;
        dvd = `VIMS_DVD_INTERLACED;
        repeat (12) @(negedge clk);
        chk("tv levels", 24'h7, {20'h0, soe_b, scb, ffb, pal_o});
        r0 = ref_clk;
        repeat (`VIMS_SYNC_DIV) @(negedge clk);
        chk("ref clk", {23'h0, ~r0}, {23'h0, ref_clk});
        dvd = `VIMS_DVD_PROGRESSIVE;
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        chk("oe in reset", 24'h1, {23'h0, soe_b});
        rst_b = 1'b1;
        repeat (6) @(negedge clk);
        chk("scan keep", 24'h0, {23'h0, scb});
        chk("dev syncs", 24'h3, {22'h0, hs_o, vs_o});
        mode = `VIMS_MODE_DAC;
        repeat (6) @(negedge clk);
        chk("sync idle", 24'h1, {23'h0, soe_b});
        tally_and_finish();
    end
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
